/* pvcs_regs.svh */
`ifndef PVCS_REGS_SVH
`define PVCS_REGS_SVH
// register indices; byte address is four times the index
`define PVCS_CFG_IDX 8'h10
`define PVCS_STS_IDX 8'h11
`define PVCS_CFG_ADDR 10'h040
`define PVCS_STS_ADDR 10'h044
`define PVCS_STATE_MACHINE_RESET_ADDR 10'h048
// configuration field positions
`define PVCS_B_BLOCK 15
`define PVCS_B_SCRAM 14
`define PVCS_B_SYMB 13
`define PVCS_B_FSD 12
`define PVCS_B_RSV11 11
`define PVCS_B_COPPER 10
`define PVCS_B_RSV9 9
`define PVCS_B_RSV8 8
`define PVCS_B_FLINK 7
`define PVCS_B_RSV6 6
`define PVCS_B_COL 5
`define PVCS_B_RPD 4
`define PVCS_B_STATE_MACHINE_RESET 3
`define PVCS_B_PRE 2
`define PVCS_B_SLEEP 1
`define PVCS_B_RLOOP 0
// reset values
`define PVCS_CFG_RST 16'h0414
`define PVCS_STS_RST 4'hf
// writable mask: bit 9 reads zero
`define PVCS_CFG_WMASK 16'hfdff
// state machine reset pulse length
`define PVCS_STATE_MACHINE_RESET_NS 64
`define PVCS_CLK_MHZ 125
`define PVCS_STATE_MACHINE_RESET_CYC ((`PVCS_STATE_MACHINE_RESET_NS * `PVCS_CLK_MHZ + 999) / 1000)
`endif

/* pvcs_pkg.sv */
package pvcs_pkg;
  // reset sequencer states, gray along idle-run-done
  typedef enum logic [1:0] {
    PVCS_IDLE = 2'b00,
    PVCS_RUN = 2'b01,
    PVCS_DONE = 2'b11
  } pvcs_rst_e;
endpackage : pvcs_pkg

/* pvcs_top.sv */
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "pvcs_regs.svh"
// What this block does
// - bit 15 bypasses block encoder and decoder
// - bit 14 bypasses scrambler and descrambler
// - bit 13 bypasses symbol alignment path
// - bit 12 forces signal detect active
// - bit 10 selects copper, zero fibre
// - bit 7 forces good fast link
// - bit 5 drives collision LED in test
// - bit 4 enables auto reduced power
// - bit 3 resets machines, self clears
// - bit 2 enables management preamble suppression
// - bit 1 sleeps all but clocking
// - waking restores config, resets machines
// - bit 0 loops receive data out
// - negotiation result latched into status bits
// - status 15 means fast full duplex
// - status 14 means fast half duplex
// - status 13 means slow full duplex
// - status 12 means slow half duplex
module pvcs_top
  import pvcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic an_done_in,
  input wire logic [1:0] an_mode_in,
  input wire logic signal_detect_ind_in,
  input wire logic link_raw_in,
  input wire logic test_mode_in,
  input wire logic collision_in,
  output logic bypass_block_coding_out,
  output logic bypass_scrambling_out,
  output logic bypass_symbol_path_out,
  output logic signal_detect_ind_out,
  output logic copper_mode_out,
  output logic link_good_out,
  output logic collision_led_ctl_out,
  output logic auto_reduced_power_en_out,
  output logic state_machine_reset_out,
  output logic mgmt_preamble_suppress_out,
  output logic sleep_out,
  output logic remote_loopback_out
);
  logic [15:0] cfg_ff;
  logic [15:0] saved_ff;
  logic [3:0] sts_ff;
  pvcs_rst_e rst_st_ff;
  logic [7:0] rst_cnt_ff;
  logic [31:0] nxt_dat;
  logic req;
  logic wr_cfg;
  logic [15:0] wdat;
  logic sm_start;

  // single-cycle access; ack dropped the cycle after
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_cfg = req && wb_we_in && (wb_adr_in == `PVCS_CFG_ADDR);
  // byte lanes merge into the low half only
  assign wdat = {wb_sel_in[1] ? wb_dat_in[15:8] : cfg_ff[15:8],
                 wb_sel_in[0] ? wb_dat_in[7:0] : cfg_ff[7:0]};
  // wake from sleep also restarts the machines
  assign sm_start = (wr_cfg && wdat[`PVCS_B_STATE_MACHINE_RESET]) ||
                    (wr_cfg && cfg_ff[`PVCS_B_SLEEP] &&
                     !wdat[`PVCS_B_SLEEP]);

  // bus ack, one cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_in)
      `PVCS_CFG_ADDR: nxt_dat = {16'h0000, cfg_ff};
      `PVCS_STS_ADDR: nxt_dat = {16'h0000, sts_ff, 12'h000};
      `PVCS_STATE_MACHINE_RESET_ADDR: nxt_dat = {30'h0, rst_st_ff};
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      wb_dat_out <= nxt_dat;
    end
  end

  // configuration register; bit 9 fixed zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_ff <= `PVCS_CFG_RST;
    end else if (wr_cfg) begin
      cfg_ff <= wdat & `PVCS_CFG_WMASK;
      if (cfg_ff[`PVCS_B_SLEEP] && !wdat[`PVCS_B_SLEEP]) begin
        // wake restores pre-sleep settings
        cfg_ff <= saved_ff & `PVCS_CFG_WMASK;
      end
    end else if (rst_st_ff == PVCS_DONE) begin
      cfg_ff[`PVCS_B_STATE_MACHINE_RESET] <= 1'b0;
    end
  end

  // snapshot taken on the write that enters sleep
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      saved_ff <= `PVCS_CFG_RST;
    end else if (wr_cfg && !cfg_ff[`PVCS_B_SLEEP] &&
                 wdat[`PVCS_B_SLEEP]) begin
      saved_ff <= cfg_ff;
    end
  end

  // state machine reset sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_st_ff <= PVCS_IDLE;
      rst_cnt_ff <= 8'h00;
    end else begin
      case (rst_st_ff)
        PVCS_IDLE: begin
          if (sm_start) begin
            rst_st_ff <= PVCS_RUN;
            rst_cnt_ff <= 8'(`PVCS_STATE_MACHINE_RESET_CYC - 1);
          end
        end
        PVCS_RUN: begin
          if (rst_cnt_ff == 8'h00) begin
            rst_st_ff <= PVCS_DONE;
          end else begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
          end
        end
        PVCS_DONE: begin
          // a write setting bit 3 or waking from sleep on the done cycle starts a fresh run,
          // otherwise bit 3 would stay set with nothing to clear it
          if (sm_start) begin
            rst_st_ff <= PVCS_RUN;
            rst_cnt_ff <= 8'(`PVCS_STATE_MACHINE_RESET_CYC - 1);
          end else begin
            rst_st_ff <= PVCS_IDLE;
          end
        end
        default: rst_st_ff <= PVCS_IDLE;
      endcase
    end
  end

  // negotiated result, one hot, written at completion
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sts_ff <= `PVCS_STS_RST;
    end else if (an_done_in) begin
      sts_ff <= 4'h1 << (2'd3 - an_mode_in);
    end
  end

  // control outputs, all registered
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bypass_block_coding_out <= 1'b0;
      bypass_scrambling_out <= 1'b0;
      bypass_symbol_path_out <= 1'b0;
      signal_detect_ind_out <= 1'b0;
      copper_mode_out <= 1'b1;
      link_good_out <= 1'b0;
      collision_led_ctl_out <= 1'b0;
      auto_reduced_power_en_out <= 1'b1;
      state_machine_reset_out <= 1'b0;
      mgmt_preamble_suppress_out <= 1'b1;
      sleep_out <= 1'b0;
      remote_loopback_out <= 1'b0;
    end else begin
      bypass_block_coding_out <= cfg_ff[`PVCS_B_BLOCK];
      bypass_scrambling_out <= cfg_ff[`PVCS_B_SCRAM];
      bypass_symbol_path_out <= cfg_ff[`PVCS_B_SYMB];
      signal_detect_ind_out <= cfg_ff[`PVCS_B_FSD] ||
                               signal_detect_ind_in;
      copper_mode_out <= cfg_ff[`PVCS_B_COPPER];
      link_good_out <= cfg_ff[`PVCS_B_FLINK] || link_raw_in;
      // test mode hands the LED to software
      collision_led_ctl_out <= test_mode_in ? cfg_ff[`PVCS_B_COL]
                                            : collision_in;
      auto_reduced_power_en_out <= cfg_ff[`PVCS_B_RPD];
      state_machine_reset_out <= (rst_st_ff == PVCS_RUN);
      mgmt_preamble_suppress_out <= cfg_ff[`PVCS_B_PRE];
      sleep_out <= cfg_ff[`PVCS_B_SLEEP];
      remote_loopback_out <= cfg_ff[`PVCS_B_RLOOP];
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");
  rsv_bit_zero_a: assert property (!cfg_ff[`PVCS_B_RSV9])
    else $error("reserved bit 9 set");
  state_machine_reset_clears_a: assert property ((rst_st_ff == PVCS_DONE) && !wr_cfg
    |=> !cfg_ff[`PVCS_B_STATE_MACHINE_RESET])
    else $error("reset bit not cleared");
  state_machine_reset_pulse_a: assert property ($rose(state_machine_reset_out)
    |-> ##[1:20] !state_machine_reset_out)
    else $error("reset pulse too long");
  status_onehot_a: assert property (an_done_in |=> $onehot(sts_ff))
    else $error("status not one hot");
  fast_full_a: assert property (an_done_in && an_mode_in == 2'd0
    |=> sts_ff[3])
    else $error("fast full not shown");
  slow_half_a: assert property (an_done_in && an_mode_in == 2'd3
    |=> sts_ff[0])
    else $error("slow half not shown");
  force_sd_a: assert property (cfg_ff[`PVCS_B_FSD]
    |=> signal_detect_ind_out)
    else $error("signal detect not forced");
  force_link_a: assert property (cfg_ff[`PVCS_B_FLINK]
    |=> link_good_out)
    else $error("link not forced");
  col_test_a: assert property (test_mode_in
    |=> collision_led_ctl_out == $past(cfg_ff[`PVCS_B_COL]))
    else $error("collision led wrong");
  wake_restart_a: assert property (wr_cfg && cfg_ff[`PVCS_B_SLEEP] &&
    !wdat[`PVCS_B_SLEEP] && rst_st_ff == PVCS_IDLE
    |=> rst_st_ff == PVCS_RUN)
    else $error("wake did not reset");

  // block coding bypass follows its bit one cycle later
  block_bypass_a: assert property (bypass_block_coding_out ==
    $past(cfg_ff[`PVCS_B_BLOCK]))
    else $error("block bypass output wrong");

  // scrambler bypass follows its bit one cycle later
  scram_bypass_a: assert property (bypass_scrambling_out ==
    $past(cfg_ff[`PVCS_B_SCRAM]))
    else $error("scrambler bypass output wrong");

  // symbol path bypass follows its bit one cycle later
  symb_bypass_a: assert property (bypass_symbol_path_out ==
    $past(cfg_ff[`PVCS_B_SYMB]))
    else $error("symbol bypass output wrong");

  // media select; reset values agree so no reset gap
  copper_sel_a: assert property (copper_mode_out ==
    $past(cfg_ff[`PVCS_B_COPPER]))
    else $error("media select output wrong");

  // automatic power reduction enable
  auto_power_a: assert property (auto_reduced_power_en_out ==
    $past(cfg_ff[`PVCS_B_RPD]))
    else $error("reduced power enable wrong");

  // management preamble suppression
  preamble_sup_a: assert property (mgmt_preamble_suppress_out ==
    $past(cfg_ff[`PVCS_B_PRE]))
    else $error("preamble suppress output wrong");

  // sleep request reaches the power control
  sleep_mirror_a: assert property (sleep_out ==
    $past(cfg_ff[`PVCS_B_SLEEP]))
    else $error("sleep output wrong");

  // remote loopback select
  loopback_mirror_a: assert property (remote_loopback_out ==
    $past(cfg_ff[`PVCS_B_RLOOP]))
    else $error("loopback output wrong");

  // without forcing, signal detect passes straight through
  sd_follow_a: assert property (!cfg_ff[`PVCS_B_FSD]
    |=> signal_detect_ind_out == $past(signal_detect_ind_in))
    else $error("signal detect not passed");

  // without forcing, the real link state is reported
  link_follow_a: assert property (!cfg_ff[`PVCS_B_FLINK]
    |=> link_good_out == $past(link_raw_in))
    else $error("link state not passed");

  // outside test mode software has no say over the led
  col_normal_a: assert property (!test_mode_in
    |=> collision_led_ctl_out == $past(collision_in))
    else $error("collision not passed");

  // writes elsewhere must leave the configuration alone
  unmapped_write_a: assert property (req && wb_we_in &&
    wb_adr_in != `PVCS_CFG_ADDR && rst_st_ff != PVCS_DONE
    |=> $stable(cfg_ff))
    else $error("config changed by other write");

  // status only moves when negotiation reports done
  status_hold_a: assert property (!an_done_in
    |=> $stable(sts_ff))
    else $error("status changed without done");

  // fast half duplex result
  fast_half_a: assert property (an_done_in && an_mode_in == 2'd1
    |=> sts_ff[2])
    else $error("fast half not shown");

  // slow full duplex result
  slow_full_a: assert property (an_done_in && an_mode_in == 2'd2
    |=> sts_ff[1])
    else $error("slow full not shown");

  // machine reset pulse is exactly the derived length
  state_machine_reset_len_a: assert property ($rose(state_machine_reset_out)
    |-> state_machine_reset_out[*8] ##1 !state_machine_reset_out)
    else $error("reset pulse length wrong");

  // entering sleep keeps the settings held before it
  sleep_snap_a: assert property (wr_cfg &&
    !cfg_ff[`PVCS_B_SLEEP] && wdat[`PVCS_B_SLEEP]
    |=> saved_ff == $past(cfg_ff))
    else $error("sleep snapshot wrong");

  // reserved bit 9 never shows on a read
  rsv_read_a: assert property (req && !wb_we_in &&
    wb_adr_in == `PVCS_CFG_ADDR |=> !wb_dat_out[`PVCS_B_RSV9])
    else $error("reserved bit read as one");

  // a written bit 3 starts the sequencer unless already running
  state_machine_reset_start_a: assert property (wr_cfg &&
    wdat[`PVCS_B_STATE_MACHINE_RESET] && rst_st_ff != PVCS_RUN
    |=> rst_st_ff == PVCS_RUN)
    else $error("machine reset not started");

  cov_wake_c: cover property (sleep_out ##[1:50] !sleep_out);
  cov_state_machine_reset_c: cover property (rst_st_ff == PVCS_DONE);
  cov_an_c: cover property (an_done_in && an_mode_in == 2'd1);
  cov_col_c: cover property (test_mode_in && cfg_ff[`PVCS_B_COL]);
  cov_fsd_c: cover property (cfg_ff[`PVCS_B_FSD] && !signal_detect_ind_in);
endmodule : pvcs_top

/* pvcs_sta_model.sv */
`timescale 1ns/1ps
module pvcs_sta_model (
  input wire logic clk_in,
  input wire logic wb_ack_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_cyc_out,
  output logic wb_stb_out,
  output logic wb_we_out,
  output logic [9:0] wb_adr_out,
  output logic [3:0] wb_sel_out,
  output logic [31:0] wb_dat_out
);
  // idle bus from time zero
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out = 1'b0;
    wb_adr_out = 10'h000;
    wb_sel_out = 4'h0;
    wb_dat_out = 32'h00000000;
  end
  // one classic cycle; a lost ack ends the run rather than hanging
  task automatic xfer(input logic we, input logic [9:0] adr,
      input logic [15:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out <= we;
    wb_adr_out <= adr;
    wb_sel_out <= 4'h3;
    wb_dat_out <= {16'h0000, wd & 16'hf7bf};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_in !== 1'b1 && n < 20);
    rd = wb_dat_in;
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_we_out <= 1'b0;
    wb_dat_out <= ~wb_dat_out; // stale data must not look valid
    if (wb_ack_in !== 1'b1) begin
      pvcs_top_tb.err_total++;
      pvcs_top_tb.stop_test();
    end
  endtask : xfer
endmodule : pvcs_sta_model

/* pvcs_top_tb.sv */
`timescale 1ns/1ps
`include "pvcs_regs.svh"
`define PVCS_CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); \
  end \
end
module pvcs_top_tb;
  logic clk_in, nrst_in, cyc, stb, we, ack, an_done;
  logic sd_in, link_raw, test_mode, collision;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [1:0] an_mode;
  logic bb, bs, bsp, sdo, cop, lg, col, rpd, smr, pre, slp, rl;
  wire [11:0] outs = {bb, bs, bsp, sdo, cop, lg, col, rpd, smr, pre, slp, rl};
  int err_total = 0;
  int check_count = 0;
  int smr_cnt = 0;
  pvcs_top i_pvcs_top (.clk_in(clk_in), .nrst_in(nrst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .an_done_in(an_done), .an_mode_in(an_mode),
    .signal_detect_ind_in(sd_in), .link_raw_in(link_raw),
    .test_mode_in(test_mode), .collision_in(collision),
    .bypass_block_coding_out(bb), .bypass_scrambling_out(bs),
    .bypass_symbol_path_out(bsp), .signal_detect_ind_out(sdo),
    .copper_mode_out(cop), .link_good_out(lg), .collision_led_ctl_out(col),
    .auto_reduced_power_en_out(rpd), .state_machine_reset_out(smr),
    .mgmt_preamble_suppress_out(pre), .sleep_out(slp),
    .remote_loopback_out(rl));
  pvcs_sta_model i_pvcs_sta_model (.clk_in(clk_in), .wb_ack_in(ack),
    .wb_dat_in(rdat), .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we),
    .wb_adr_out(adr), .wb_sel_out(sel), .wb_dat_out(wdat));
  // 125 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // counts every cycle the machine reset is held
  always @(posedge clk_in) if (smr === 1'b1) smr_cnt++;
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    i_pvcs_sta_model.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [9:0] a,
      input logic [31:0] e);
    i_pvcs_sta_model.xfer(1'b0, a, 16'h0000, rd);
    `PVCS_CHK(nm, e, rd)
  endtask : rd_chk
  // outputs follow the register one cycle late
  task automatic out_chk(input logic [11:0] e);
    repeat (2) @(posedge clk_in);
    `PVCS_CHK("outputs", e, outs)
  endtask : out_chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    nrst_in = 1'b0;
    {an_done, an_mode, sd_in, link_raw, test_mode, collision} = '0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk("cfg reset", `PVCS_CFG_ADDR, 32'h00000414);
    rd_chk("sts reset", `PVCS_STS_ADDR, 32'h0000f000);
    out_chk(12'h094);
    $display("test reset done");
    test_mode <= 1'b1;
    wr(`PVCS_CFG_ADDR, 16'hf2a5);
    rd_chk("cfg bit9", `PVCS_CFG_ADDR, 32'h0000f0a5);
    out_chk(12'hf65);
    @(posedge clk_in);
    test_mode <= 1'b0;
    out_chk(12'hf45);
    @(posedge clk_in);
    {sd_in, link_raw, collision} <= 3'b111;
    wr(`PVCS_CFG_ADDR, 16'h0000);
    out_chk(12'h160);
    $display("test config done");
    // status only read after negotiation reports done
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_in);
      an_mode <= 2'(m);
      an_done <= 1'b1;
      @(posedge clk_in);
      an_done <= 1'b0;
      rd_chk("sts mode", `PVCS_STS_ADDR, 32'h8000 >> m);
    end
    $display("test status done");
    smr_cnt = 0;
    wr(`PVCS_CFG_ADDR, 16'h0008);
    rd_chk("seq run", `PVCS_STATE_MACHINE_RESET_ADDR, 32'h00000001);
    repeat (40) @(posedge clk_in);
    `PVCS_CHK("smr len", `PVCS_STATE_MACHINE_RESET_CYC, smr_cnt)
    rd_chk("smr clear", `PVCS_CFG_ADDR, 32'h00000000);
    rd_chk("seq idle", `PVCS_STATE_MACHINE_RESET_ADDR, 32'h00000000);
    wr(`PVCS_CFG_ADDR, 16'h0001);
    wr(`PVCS_CFG_ADDR, 16'h0003);
    out_chk(12'h163);
    smr_cnt = 0;
    wr(`PVCS_CFG_ADDR, 16'h0000);
    repeat (40) @(posedge clk_in);
    `PVCS_CHK("wake smr", `PVCS_STATE_MACHINE_RESET_CYC, smr_cnt)
    rd_chk("wake cfg", `PVCS_CFG_ADDR, 32'h00000001);
    $display("test machine reset done");
    wr(10'h3fc, 16'hffff);
    rd_chk("unmapped", 10'h3fc, 32'h00000000);
    rd_chk("cfg kept", `PVCS_CFG_ADDR, 32'h00000001);
    $display("test unmapped done");
    stop_test();
  end
endmodule : pvcs_top_tb
